// [core/spi_host_regs.vh]
// Register offsets, field positions and timing counts of the serial flash host controller
`ifndef SPI_HOST_REGS_VH
`define SPI_HOST_REGS_VH
// Register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_CMD         8'h04
`define REG_ADDR        8'h08
`define REG_LEN         8'h0C
`define REG_WDATA       8'h10
`define REG_RDATA       8'h14
`define REG_STAT        8'h18
// Control fields
`define CTRL_START      0
`define CTRL_HAS_ADDR   1
`define CTRL_ADDR32     2
`define CTRL_HAS_MODE   3
`define CTRL_READ       4
`define CTRL_DDR        5
`define CTRL_QPI        6
`define CTRL_CONT       7
`define CTRL_WID_LO     8
`define CTRL_WID_HI     9
`define CTRL_CPOL       10
`define CTRL_DUMMY_LO   12
`define CTRL_DUMMY_HI   16
// Status fields
`define STAT_BUSY       0
`define STAT_RVALID     1
`define STAT_WREADY     2
// Reset values
`define CTRL_RESET      32'h0000_0000
// Half period of the link clock in core cycles
`define HALF_PERIOD     4
`endif

// [core/spi_host.v]
// Host controller that drives a multi-lane serial flash over select, clock and four lanes
`timescale 1ns/1ps
`include "spi_host_regs.vh"
module spi_host #(
  parameter HALF = `HALF_PERIOD
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // Register port
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // Flash pins
  output reg         select_n,
  output reg         sclk,
  output reg  [3:0]  lane_out,
  output reg  [3:0]  lane_oe,
  input  wire [3:0]  lane_in
);
  localparam S_IDLE = 3'd0;
  localparam S_INST = 3'd1;
  localparam S_ADDR = 3'd2;
  localparam S_MODE = 3'd3;
  localparam S_DUMY = 3'd4;
  localparam S_WDAT = 3'd5;
  localparam S_RDAT = 3'd6;
  localparam S_DONE = 3'd7;

  reg [31:0] ctrl_q;
  reg [7:0]  cmd_q;
  reg [31:0] addr_q;
  reg [15:0] len_q;
  reg [7:0]  wbuf_q;
  reg        wfull_q;
  reg [7:0]  rbuf_q;
  reg        rvalid_q;
  reg [2:0]  state_q;
  reg [31:0] sh_q;
  reg [5:0]  bits_q;
  reg [2:0]  rbits_q;
  reg [4:0]  dummy_q;
  reg [7:0]  div_q;
  reg [3:0]  in1_q;
  reg [3:0]  in2_q;
  reg        armed_q;

  wire [1:0] wid  = ctrl_q[`CTRL_WID_HI:`CTRL_WID_LO];
  wire       ddr  = ctrl_q[`CTRL_DDR];
  wire       quad_peripheral_mode  = ctrl_q[`CTRL_QPI];
  // Lanes per transfer: 1, 2 or 4
  wire [2:0] step = (wid == 2'd2) ? 3'd4 : (wid == 2'd1) ? 3'd2 : 3'd1;
  wire [2:0] istep = quad_peripheral_mode ? 3'd4 : 3'd1;
  wire       tick = (div_q == HALF[7:0] - 8'd1);
  // Falling edge of the link clock in mode 0 sense: clock high now
  wire       fall = tick && sclk;
  wire       rise = tick && !sclk;
  wire       busy = (state_q != S_IDLE);
  // Write phase with no byte loaded: clock is held until software supplies one
  wire       stall = (state_q == S_WDAT) && (bits_q == 6'd0);

  ////////////////////////////////////////////////////////////////////////
  // Input synchroniser
  always @(posedge core_clk) begin
    if (!rstn) begin
      in1_q <= 4'h0;
      in2_q <= 4'h0;
    end else begin
      in1_q <= lane_in;
      in2_q <= in1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port
  always @(posedge core_clk) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= 32'h0000_0000;
      if (rd) begin
        case (addr)
          `REG_CTRL:  rdata <= ctrl_q;
          `REG_CMD:   rdata <= {24'h00_0000, cmd_q};
          `REG_ADDR:  rdata <= addr_q;
          `REG_LEN:   rdata <= {16'h0000, len_q};
          `REG_RDATA: rdata <= {24'h00_0000, rbuf_q};
          `REG_STAT:  rdata <= {29'h0, !wfull_q, rvalid_q, busy};
          default:    rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command engine
  always @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_q   <= `CTRL_RESET;
      cmd_q    <= 8'h00;
      addr_q   <= 32'h0000_0000;
      len_q    <= 16'h0000;
      wbuf_q   <= 8'h00;
      wfull_q  <= 1'b0;
      rbuf_q   <= 8'h00;
      rvalid_q <= 1'b0;
      state_q  <= S_IDLE;
      sh_q     <= 32'h0000_0000;
      bits_q   <= 6'd0;
      rbits_q  <= 3'd0;
      dummy_q  <= 5'd0;
      div_q    <= 8'h00;
      armed_q  <= 1'b0;
      select_n <= 1'b1;
      sclk     <= 1'b0;
      lane_out <= 4'h0;
      lane_oe  <= 4'h0;
    end else begin
      if (wr && !busy) begin
        case (addr)
          `REG_CTRL: ctrl_q <= wdata & 32'hFFFF_FFFE;
          `REG_CMD:  cmd_q  <= wdata[7:0];
          `REG_ADDR: addr_q <= wdata;
          `REG_LEN:  len_q  <= wdata[15:0];
          default:   ctrl_q <= ctrl_q;
        endcase
      end
      if (wr && addr == `REG_WDATA && !wfull_q) begin
        wbuf_q  <= wdata[7:0];
        wfull_q <= 1'b1;
      end
      // Reading the data register frees the slot
      if (rd && addr == `REG_RDATA)
        rvalid_q <= 1'b0;
      div_q <= (tick || state_q == S_IDLE) ? 8'h00 : div_q + 8'h01;
      case (state_q)
        S_IDLE: begin
          sclk    <= ctrl_q[`CTRL_CPOL];
          lane_oe <= 4'h0;
          if (wr && addr == `REG_CTRL && wdata[`CTRL_START]) begin
            ctrl_q   <= wdata & 32'hFFFF_FFFE;
            select_n <= 1'b0;
            // parked level kept across the select edge only when this write leaves CPOL unchanged
            sclk     <= wdata[`CTRL_CPOL];
            armed_q  <= 1'b0;
            dummy_q  <= wdata[`CTRL_DUMMY_HI:`CTRL_DUMMY_LO];
            if (wdata[`CTRL_CONT]) begin
              state_q <= S_ADDR;
              sh_q    <= addr_q;
              bits_q  <= wdata[`CTRL_ADDR32] ? 6'd32 : 6'd24;
            end else begin
              state_q <= S_INST;
              sh_q    <= {cmd_q, 24'h00_0000};
              bits_q  <= 6'd8;
            end
          end
        end
        S_DONE: begin
          if (tick) begin
            select_n <= 1'b1;
            lane_oe  <= 4'h0;
            state_q  <= S_IDLE;
          end
        end
        default: begin
          if (tick && !stall)
            sclk <= !sclk;
          // a cycle counts only after a rising edge was sent
          if (rise && !stall)
            armed_q <= 1'b1;
          if (stall && wfull_q) begin
            sh_q    <= {wbuf_q, 24'h00_0000};
            wfull_q <= 1'b0;
            bits_q  <= 6'd8;
            len_q   <= len_q - 16'h0001;
          end
          // lanes follow the shifter, which moves at falling edges and when a stalled write byte is loaded
          if (state_q != S_RDAT && state_q != S_DUMY) begin
            // Settled several core cycles before the next rising edge, but after a stalled write byte load they can change at that edge
            // lane0 least significant
            if (state_q == S_INST && !quad_peripheral_mode) begin
              lane_out <= {3'b000, sh_q[31]};
              lane_oe  <= 4'h1;
            end else if (state_q == S_INST || quad_peripheral_mode || step == 3'd4) begin
              lane_out <= sh_q[31:28];
              lane_oe  <= 4'hF;
            end else if (step == 3'd2) begin
              lane_out <= {2'b00, sh_q[31:30]};
              lane_oe  <= 4'h3;
            end else begin
              lane_out <= {3'b000, sh_q[31]};
              lane_oe  <= 4'h1;
            end
          end else begin
            lane_oe <= 4'h0;
          end
          // Device samples on rising edge; host shifts on the falling edge
          if (fall && armed_q) begin
            case (state_q)
              S_INST, S_ADDR, S_MODE, S_WDAT: begin
                if (state_q == S_INST) begin
                  sh_q   <= sh_q << istep;
                  bits_q <= bits_q - {3'b000, istep};
                end else begin
                  sh_q   <= sh_q << (quad_peripheral_mode ? 3'd4 : step);
                  bits_q <= bits_q - {3'b000, (quad_peripheral_mode ? 3'd4 : step)};
                end
                if (bits_q <= {3'b000, (state_q == S_INST ? istep : (quad_peripheral_mode ? 3'd4 : step))})
                begin
                  if (state_q == S_INST && ctrl_q[`CTRL_HAS_ADDR]) begin
                    state_q <= S_ADDR;
                    sh_q    <= ctrl_q[`CTRL_ADDR32] ? addr_q : {addr_q[23:0], 8'h00};
                    bits_q  <= ctrl_q[`CTRL_ADDR32] ? 6'd32 : 6'd24;
                  end else if (state_q == S_ADDR && ctrl_q[`CTRL_HAS_MODE]) begin
                    state_q <= S_MODE;
                    sh_q    <= {ctrl_q[`CTRL_CONT] ? 8'hA0 : 8'h00, 24'h00_0000};
                    bits_q  <= 6'd8;
                  end else if (ctrl_q[`CTRL_READ]) begin
                    state_q <= (dummy_q == 5'd0) ? S_RDAT : S_DUMY;
                    rbits_q <= 3'd0;
                  end else if (len_q != 16'h0000 && wfull_q) begin
                    state_q <= S_WDAT;
                    sh_q    <= {wbuf_q, 24'h00_0000};
                    wfull_q <= 1'b0;
                    bits_q  <= 6'd8;
                    len_q   <= len_q - 16'h0001;
                  end else if (len_q != 16'h0000) begin
                    // Wait for software to supply a byte with clock held
                    state_q <= S_WDAT;
                    bits_q  <= 6'd0;
                  end else begin
                    state_q <= S_DONE;
                  end
                end
              end
              S_DUMY: begin
                lane_oe <= 4'h0;
                dummy_q <= dummy_q - 5'd1;
                if (dummy_q == 5'd1)
                  state_q <= S_RDAT;
              end
              S_RDAT: begin
                lane_oe <= 4'h0;
                if (!rvalid_q) begin
                  if (quad_peripheral_mode || step == 3'd4)
                    rbuf_q <= {rbuf_q[3:0], in2_q};
                  else if (step == 3'd2)
                    rbuf_q <= {rbuf_q[5:0], in2_q[1:0]};
                  else
                    rbuf_q <= {rbuf_q[6:0], in2_q[1]};
                  rbits_q <= rbits_q + ((quad_peripheral_mode || step == 3'd4) ? 3'd4 : step);
                  if (rbits_q + ((quad_peripheral_mode || step == 3'd4) ? 3'd4 : step) == 3'd0) begin
                    rvalid_q <= 1'b1;
                    len_q    <= len_q - 16'h0001;
                    if (len_q == 16'h0001)
                      state_q <= S_DONE;
                  end
                end
              end
              default: state_q <= S_DONE;
            endcase
          end
        end
      endcase
    end
  end

endmodule // spi_host

// [tb/spi_host_asserts.sv]
// Pin level checks on the serial flash host controller
`timescale 1ns/1ps
module spi_host_asserts (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // Flash pins
  input wire logic       select_n,
  input wire logic       sclk,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [7:0] gap_q;
  // Cycles since the last clock edge inside a frame
  always @(posedge core_clk)
    if (!rstn || select_n || $changed(sclk)) gap_q <= 8'h00;
    else gap_q <= gap_q + 8'h01;
  //////////////////////////////////////////
  property p_frame_hold; $fell(select_n) |-> (!select_n)[*8]; endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("frame too short");
  property p_oe_idle; select_n && $past(select_n) |-> lane_oe == 4'h0; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("lanes driven while idle");
  property p_half; !select_n && $changed(sclk) |=> (select_n || $stable(sclk))[*3]; endproperty
  a_half: assert property (p_half) else $error("clock half period short");
  property p_setup; !select_n && $rose(sclk) |-> $stable(lane_out) ##1 $stable(lane_out);
  endproperty
  a_setup: assert property (p_setup) else $error("lane data moved at rising edge");
  property p_oe_setup; !select_n && $rose(sclk) |-> $stable(lane_oe); endproperty
  a_oe_setup: assert property (p_oe_setup) else $error("lane enable moved at rising edge");
  property p_start_quiet; $fell(select_n) |-> $stable(sclk); endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("clock edge at frame start");
  property p_end_quiet; $rose(select_n) |-> $stable(sclk); endproperty
  a_end_quiet: assert property (p_end_quiet) else $error("clock edge at frame end");
  property p_toggle; !select_n |-> gap_q < 8'h40; endproperty
  a_toggle: assert property (p_toggle) else $error("clock stalled in frame");
endmodule // spi_host_asserts

// [tb/flash_model.sv]
// Behavioural serial flash answering the host controller
`timescale 1ns/1ps
module flash_model (
  // Host side
  input  wire logic        select_n,
  input  wire logic        sclk,
  input  wire logic [3:0]  host_out,
  input  wire logic [3:0]  host_oe,
  // Rising edges before read data
  input  wire logic [7:0]  lead,
  // Resolved lanes and captured bits
  output logic      [3:0]  lane,
  output logic      [39:0] hdr,
  output logic      [7:0]  cnt
);
  logic [3:0] dev_out = 4'h0;
  logic [3:0] dev_oe = 4'h0;
  logic [3:0] last = 4'h0;
  logic [7:0] idx;
  logic [7:0] byte_v;
  // undriven lanes 2 and 3 pull high, others show the inverse of the last level
  always_comb
    for (int i = 0; i < 4; i++)
      lane[i] = host_oe[i] ? host_out[i] : dev_oe[i] ? dev_out[i] : (i > 1) ? 1'b1 : ~last[i];
  always @(negedge select_n) begin
    cnt = 8'h00;
    hdr = 40'h0;
  end
  // sample MSB first on rising edges
  always @(posedge sclk) if (!select_n) begin
    last <= lane;
    if (cnt < 8'd40) hdr <= {hdr[38:0], lane[0]};
    cnt <= cnt + 8'h01;
  end
  // read bits from falling edges, byte address increments
  always @(negedge sclk) if (!select_n && cnt >= lead) begin
    idx = cnt - lead;
    byte_v = 8'hC3 + {3'h0, idx[7:3]};
    dev_oe <= 4'h2;
    dev_out <= {2'h0, byte_v[3'h7 - idx[2:0]], 1'b0};
  end
  always @(posedge select_n) dev_oe <= 4'h0;
endmodule // flash_model

// [tb/spi_host_bench.sv]
// Register level bench of the serial flash host controller
`timescale 1ns/1ps
`include "spi_host_regs.vh"
module spi_host_bench;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  lead = 8'hFF;
  logic [31:0] v;
  wire  [31:0] rdata;
  wire         select_n;
  wire         sclk;
  wire  [3:0]  lane_out;
  wire  [3:0]  lane_oe;
  wire  [3:0]  lane_in;
  wire  [39:0] hdr;
  wire  [7:0]  cnt;
  int          num_errors = 0;
  int          n_compared = 0;
  always #10 core_clk = ~core_clk;
  spi_host spi_host_inst (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .select_n(select_n), .sclk(sclk),
    .lane_out(lane_out), .lane_oe(lane_oe), .lane_in(lane_in));
  flash_model flash_model_inst (.select_n(select_n), .sclk(sclk), .host_out(lane_out),
    .host_oe(lane_oe), .lead(lead), .lane(lane_in), .hdr(hdr), .cnt(cnt));
  //////////////////////////////////////////
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a; rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_stat(input int b, input logic val);
    for (int i = 0; i < 600; i++) begin
      rd_reg(`REG_STAT, v);
      if (v[b] === val) return;
    end
    check(40'(b), 40'hFF);
  endtask
  //////////////////////////////////////////
  initial begin
    #200000;
    num_errors++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    rd_reg(`REG_CTRL, v);
    check(40'(v), 40'(`CTRL_RESET));
    check({35'h0, select_n, lane_oe}, 40'h10);
    // Stand-alone instruction, mode 0
    wr_reg(`REG_CMD, 32'h06);
    wr_reg(`REG_CTRL, 32'h1);
    wait_stat(`STAT_BUSY, 1'b0);
    check(40'(cnt), 40'h08);
    check(40'(hdr[7:0]), 40'h06);
    check(40'(sclk), 40'h0);
    // Single lane write of one byte after a 24-bit address
    wr_reg(`REG_CMD, 32'h02);
    wr_reg(`REG_ADDR, 32'h12_3456);
    wr_reg(`REG_LEN, 32'h1);
    wr_reg(`REG_CTRL, 32'h3);
    wait_stat(`STAT_WREADY, 1'b1);
    wr_reg(`REG_WDATA, 32'h5A);
    wait_stat(`STAT_BUSY, 1'b0);
    check(40'(cnt), 40'h28);
    check(hdr, 40'h02_1234_565A);
    // Mode 3 read of two bytes
    lead <= 8'd32;
    wr_reg(`REG_CTRL, 32'h400);
    repeat (4) @(posedge core_clk);
    check(40'(sclk), 40'h1);
    wr_reg(`REG_CMD, 32'h03);
    wr_reg(`REG_ADDR, 32'hAB_CDEF);
    wr_reg(`REG_LEN, 32'h2);
    wr_reg(`REG_CTRL, 32'h413);
    for (int k = 0; k < 2; k++) begin
      wait_stat(`STAT_RVALID, 1'b1);
      rd_reg(`REG_RDATA, v);
      check(40'(v[7:0]), 40'(8'hC3 + k));
    end
    wait_stat(`STAT_BUSY, 1'b0);
    check(40'(hdr[39:8]), 40'h03AB_CDEF);
    check(40'(sclk), 40'h1);
    close_out;
  end
endmodule // spi_host_bench
bind spi_host spi_host_asserts spi_host_asserts_inst (.core_clk(core_clk), .rstn(rstn),
  .select_n(select_n), .sclk(sclk), .lane_out(lane_out), .lane_oe(lane_oe));
